/* verilog/dcs_ctrl.sv */
// command spacing controller driving a ddr3 device's command pins
// assumes ce_i low also stops the memory clock; one command per cycle
// Function
// - read to precharge same bank at least max(4 clocks, 7.5 ns)
// - write transaction start to read at least max(4 clocks, 7.5 ns)
// - write with auto precharge to activate same bank waits WR+tRP
// - mode register sets at least 4 clocks apart
// - after mode set, other commands wait max(12 clocks, 15 ns)
// - column commands at least 4 clocks apart
// - after leaving multi-purpose register mode wait 1 clock
// - 1KB page: activates spaced max(4 clocks, grade time)
// - 2KB page: activates spaced max(4 clocks, grade time)
// - 1KB page: at most four activates per rolling window
// - 2KB page: at most four activates per rolling window
// - write strobe preamble at least 0.9 clock before data
// - write strobe postamble at least 0.3 clock after data
module dcs_ctrl #(
  parameter int CL       = 5,
  parameter int CWL      = 5,
  parameter bit PAGE_2KB = 1'b0,
  parameter int TRP_PS   = 15000
) (
  input  wire logic             ref_clk_i,
  input  wire logic             resetn_i,
  input  wire logic             ce_i,
  input  wire logic             req_valid_i,
  input  dcs_pkg::dcs_cmd_e     req_cmd_i,
  input  wire logic [2:0]       req_bank_i,
  input  wire logic             req_ap_i,
  input  wire logic             req_dll_reset_i,
  input  wire logic             req_mpr_exit_i,
  output logic                  req_ready_o,
  output dcs_pkg::dcs_cmd_e     ddr_cmd_o,
  output logic [2:0]            ddr_bank_o,
  output logic                  ddr_ap_o,
  output logic                  rd_win_o,
  output logic                  wr_dqs_oe_n_o,
  output logic                  wr_data_en_o
);
  localparam int DAL_CYC = dcs_pkg::WR_CYC + dcs_pkg::ceil_ck(TRP_PS);
  localparam int FAW_CYC = PAGE_2KB ? dcs_pkg::FAW2_CYC : dcs_pkg::FAW1_CYC;
  localparam int WTR_LD  = CWL + dcs_pkg::BL_HALF + dcs_pkg::WTR_CYC;
  localparam int RD_LO   = CL - dcs_pkg::PRE_NCK;
  localparam int RD_HI   = CL + dcs_pkg::BL_HALF - 1;
  localparam int WR_LO   = CWL - dcs_pkg::PRE_NCK;
  localparam int WR_HI   = CWL + dcs_pkg::BL_HALF - 1 + dcs_pkg::PST_NCK;

  if (CL < 2 || CWL < 2 || WR_HI >= dcs_pkg::PW - 1 ||
      RD_HI >= dcs_pkg::PW - 1 || DAL_CYC >= 1023 || WTR_LD >= 1023)
  begin : g_bad_param
    $error("dcs_ctrl: latency or tRP out of range");
  end

  dcs_pkg::dcs_st_s st_q, st_d;
  logic             issue;

  function automatic logic [dcs_pkg::CW-1:0] ld(input int n);
    return dcs_pkg::CW'(n);
  endfunction

  function automatic logic [dcs_pkg::CW-1:0] dec(
    input logic [dcs_pkg::CW-1:0] c);
    return (c == '0) ? c : c - 1'b1;
  endfunction

  // a request taken now reaches the pins next edge, so one left is enough
  function automatic logic ok(input logic [dcs_pkg::CW-1:0] c);
    return c <= ld(1);
  endfunction

  function automatic logic win(input logic [dcs_pkg::PW-1:0] p,
                               input int lo, input int hi);
    logic h;
    h = 1'b0;
    for (int i = 0; i < dcs_pkg::PW; i++) begin
      if (i >= lo && i <= hi) begin
        h = h | p[i];
      end
    end
    return h;
  endfunction

  always_comb begin
    unique case (req_cmd_i)
      dcs_pkg::DCS_NOP: req_ready_o = 1'b1;
      dcs_pkg::DCS_ACT: req_ready_o = ok(st_q.rrd)
                          && ok(st_q.faw[st_q.faw_ptr])
                          && ok(st_q.dal[req_bank_i])
                          && ok(st_q.mods) && ok(st_q.mpr);
      dcs_pkg::DCS_RD:  req_ready_o = ok(st_q.ccd)
                          && ok(st_q.wtr)
                          && ok(st_q.dll)
                          && ok(st_q.mods) && ok(st_q.mpr);
      dcs_pkg::DCS_WR:  req_ready_o = ok(st_q.ccd) && ok(st_q.dll)
                          && ok(st_q.mods) && ok(st_q.mpr);
      dcs_pkg::DCS_PRE: req_ready_o = ok(st_q.rtp[req_bank_i])
                          && ok(st_q.mods) && ok(st_q.mpr);
      dcs_pkg::DCS_MRS: req_ready_o = ok(st_q.mrd)
                          && ok(st_q.mpr);
      default:          req_ready_o = 1'b0;
    endcase
  end

  assign issue = req_valid_i && req_ready_o &&
                 (req_cmd_i != dcs_pkg::DCS_NOP);

  always_comb begin
    st_d = st_q;
    for (int b = 0; b < dcs_pkg::NBANK; b++) begin
      st_d.rtp[b] = dec(st_q.rtp[b]);
      st_d.dal[b] = dec(st_q.dal[b]);
    end
    for (int f = 0; f < 4; f++) begin
      st_d.faw[f] = dec(st_q.faw[f]);
    end
    st_d.wtr  = dec(st_q.wtr);
    st_d.mrd  = dec(st_q.mrd);
    st_d.mods = dec(st_q.mods);
    st_d.ccd  = dec(st_q.ccd);
    st_d.mpr  = dec(st_q.mpr);
    st_d.rrd  = dec(st_q.rrd);
    st_d.dll  = dec(st_q.dll);
    st_d.cmd  = dcs_pkg::DCS_NOP;
    st_d.bank = st_q.bank;
    st_d.ap   = 1'b0;
    st_d.rd_pipe = {st_q.rd_pipe[dcs_pkg::PW-2:0], 1'b0};
    st_d.wr_pipe = {st_q.wr_pipe[dcs_pkg::PW-2:0], 1'b0};
    if (issue) begin
      st_d.cmd  = req_cmd_i;
      st_d.bank = req_bank_i;
      st_d.ap   = req_ap_i;
      unique case (req_cmd_i)
        dcs_pkg::DCS_ACT: begin
          st_d.rrd = ld(dcs_pkg::RRD_CYC);
          st_d.faw[st_q.faw_ptr] = ld(FAW_CYC);
          st_d.faw_ptr = st_q.faw_ptr + 2'h1;
        end
        dcs_pkg::DCS_RD: begin
          st_d.ccd = ld(dcs_pkg::CCD_NCK);
          st_d.rtp[req_bank_i] = ld(dcs_pkg::RTP_CYC);
          st_d.rd_pipe[0] = 1'b1;
        end
        dcs_pkg::DCS_WR: begin
          st_d.ccd = ld(dcs_pkg::CCD_NCK);
          // write transaction starts after the data burst
          st_d.wtr = ld(WTR_LD);
          if (req_ap_i) begin
            st_d.dal[req_bank_i] = ld(DAL_CYC);
          end
          st_d.wr_pipe[0] = 1'b1;
        end
        dcs_pkg::DCS_MRS: begin
          st_d.mrd  = ld(dcs_pkg::MRD_NCK);
          st_d.mods = ld(dcs_pkg::MOD_CYC);
          if (req_dll_reset_i) begin
            st_d.dll = ld(dcs_pkg::DLLK_NCK);
          end
          if (req_mpr_exit_i) begin
            st_d.mpr = ld(dcs_pkg::MPRR_NCK + 1);
          end
        end
        default: begin
        end
      endcase
    end
    // capture window spans the device's strobe preamble to release
    st_d.rd_win   = win(st_d.rd_pipe, RD_LO, RD_HI);
    st_d.dqs_oe_n = !win(st_d.wr_pipe, WR_LO, WR_HI);
    st_d.wdata_en = win(st_d.wr_pipe, CWL, CWL + dcs_pkg::BL_HALF - 1);
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_q          <= '0;
      st_q.cmd      <= dcs_pkg::DCS_NOP;
      st_q.dqs_oe_n <= 1'b1;
    end else if (ce_i) begin
      st_q <= st_d;
    end
  end

  assign ddr_cmd_o     = st_q.cmd;
  assign ddr_bank_o    = st_q.bank;
  assign ddr_ap_o      = st_q.ap;
  assign rd_win_o      = st_q.rd_win;
  assign wr_dqs_oe_n_o = st_q.dqs_oe_n;
  assign wr_data_en_o  = st_q.wdata_en;

  // helper: cycles since each read, write, mode set and activate last showed on the pins
  localparam int RTP_A  = dcs_pkg::RTP_CYC;
  localparam int MRD_A  = dcs_pkg::MRD_NCK;
  localparam int MOD_A  = dcs_pkg::MOD_CYC;
  localparam int CCD_A  = dcs_pkg::CCD_NCK;
  localparam int RRD_A  = dcs_pkg::RRD_CYC;
  localparam int DLL_A  = dcs_pkg::DLLK_NCK;
  localparam int WR_LO1 = WR_LO - 1;
  logic [dcs_pkg::CW-1:0] s_rd, s_wr, s_mrs, s_col, s_act, s_dll;
  logic [2:0]             rd_bank_q;

  function automatic logic [dcs_pkg::CW-1:0] inc(
    input logic [dcs_pkg::CW-1:0] c);
    return (&c) ? c : c + 1'b1;
  endfunction

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_rd      <= '1;
      s_wr      <= '1;
      s_mrs     <= '1;
      s_col     <= '1;
      s_act     <= '1;
      s_dll     <= '1;
      rd_bank_q <= 3'h0;
    end else if (ce_i) begin
      s_rd  <= (ddr_cmd_o == dcs_pkg::DCS_RD) ? ld(1) : inc(s_rd);
      s_wr  <= (ddr_cmd_o == dcs_pkg::DCS_WR) ? ld(1) : inc(s_wr);
      s_mrs <= (ddr_cmd_o == dcs_pkg::DCS_MRS) ? ld(1) : inc(s_mrs);
      s_act <= (ddr_cmd_o == dcs_pkg::DCS_ACT) ? ld(1) : inc(s_act);
      s_col <= (ddr_cmd_o == dcs_pkg::DCS_RD ||
                ddr_cmd_o == dcs_pkg::DCS_WR) ? ld(1) : inc(s_col);
      // only the resetting mode set restarts it, not one during lock
      s_dll <= (ddr_cmd_o == dcs_pkg::DCS_MRS && st_q.dll == ld(DLL_A))
               ? ld(1) : inc(s_dll);
      if (ddr_cmd_o == dcs_pkg::DCS_RD) begin
        rd_bank_q <= ddr_bank_o;
      end
    end
  end

  property p_rtp;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    (ce_i && ddr_cmd_o == dcs_pkg::DCS_PRE && ddr_bank_o == rd_bank_q)
      |-> s_rd >= ld(RTP_A);
  endproperty
  a_rtp: assert property (p_rtp) else $error("read to precharge short");

  property p_wtr;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    (ce_i && ddr_cmd_o == dcs_pkg::DCS_RD) |-> s_wr >= ld(WTR_LD);
  endproperty
  a_wtr: assert property (p_wtr) else $error("write to read short");

  property p_mrd;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    (ce_i && ddr_cmd_o == dcs_pkg::DCS_MRS) |-> s_mrs >= ld(MRD_A);
  endproperty
  a_mrd: assert property (p_mrd) else $error("mode sets too close");

  property p_mod;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    (ce_i && ddr_cmd_o != dcs_pkg::DCS_MRS && ddr_cmd_o != dcs_pkg::DCS_NOP)
      |-> s_mrs >= ld(MOD_A);
  endproperty
  a_mod: assert property (p_mod) else $error("mode update short");

  property p_ccd;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    (ce_i && (ddr_cmd_o == dcs_pkg::DCS_RD || ddr_cmd_o == dcs_pkg::DCS_WR))
      |-> s_col >= ld(CCD_A);
  endproperty
  a_ccd: assert property (p_ccd) else $error("column spacing short");

  property p_rrd;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    (ce_i && ddr_cmd_o == dcs_pkg::DCS_ACT) |-> s_act >= ld(RRD_A);
  endproperty
  a_rrd: assert property (p_rrd) else $error("activates too close");

  property p_dll;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    (ce_i && ddr_cmd_o == dcs_pkg::DCS_RD) |-> s_dll >= ld(DLL_A);
  endproperty
  a_dll: assert property (p_dll) else $error("read before dll lock");

  property p_wpre;
    @(posedge ref_clk_i) disable iff (!resetn_i || !ce_i)
    (st_q.wr_pipe[0] && st_q.wr_pipe[dcs_pkg::PW-1:1] == '0)
      |-> ##WR_LO1 (wr_dqs_oe_n_o && !wr_data_en_o)
          ##1 (!wr_dqs_oe_n_o && !wr_data_en_o)
          ##1 (!wr_dqs_oe_n_o && wr_data_en_o)[*4]
          // a write one column slot later may start its data here
          ##1 (!wr_dqs_oe_n_o &&
               (!wr_data_en_o || st_q.wr_pipe[CWL]));
  endproperty
  a_wpre: assert property (p_wpre)
    else $error("write strobe frame bad");

  property p_rwin;
    @(posedge ref_clk_i) disable iff (!resetn_i || !ce_i)
    (ce_i && ddr_cmd_o == dcs_pkg::DCS_RD) |-> ##RD_LO rd_win_o[*5];
  endproperty
  a_rwin: assert property (p_rwin)
    else $error("read window misplaced");
endmodule

/* inc/dcs_pkg.sv */
// constants and types for the ddr3 command spacing controller
// assumes a 125 MHz command clock and burst length 8 on the device
package dcs_pkg;
  localparam int CLK_PS    = 8000;
  localparam int CW        = 10;
  localparam int PW        = 32;
  localparam int NBANK     = 8;
  localparam int BL_HALF   = 4;
  localparam int T_RTP_PS  = 7500;
  localparam int T_WTR_PS  = 7500;
  localparam int T_WR_PS   = 15000;
  localparam int T_MOD_PS  = 15000;
  localparam int T_RRD_PS  = 10000;
  localparam int T_FAW1_PS = 40000;
  localparam int T_FAW2_PS = 50000;
  localparam int RTP_NCK   = 4;
  localparam int WTR_NCK   = 4;
  localparam int MRD_NCK   = 4;
  localparam int MOD_NCK   = 12;
  localparam int CCD_NCK   = 4;
  localparam int MPRR_NCK  = 1;
  localparam int RRD_NCK   = 4;
  localparam int DLLK_NCK  = 512;
  localparam int PRE_NCK   = 1;
  localparam int PST_NCK   = 1;

  // least time rounds up, never below one cycle
  function automatic int ceil_ck(input int ps);
    int c;
    c = (ps + CLK_PS - 1) / CLK_PS;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int max_ck(input int nck, input int ps);
    return (ceil_ck(ps) > nck) ? ceil_ck(ps) : nck;
  endfunction

  localparam int RTP_CYC  = max_ck(RTP_NCK, T_RTP_PS);
  localparam int WTR_CYC  = max_ck(WTR_NCK, T_WTR_PS);
  localparam int WR_CYC   = ceil_ck(T_WR_PS);
  localparam int MOD_CYC  = max_ck(MOD_NCK, T_MOD_PS);
  localparam int RRD_CYC  = max_ck(RRD_NCK, T_RRD_PS);
  localparam int FAW1_CYC = ceil_ck(T_FAW1_PS);
  localparam int FAW2_CYC = ceil_ck(T_FAW2_PS);

  typedef enum logic [2:0] {
    DCS_NOP, DCS_ACT, DCS_RD, DCS_WR, DCS_PRE, DCS_MRS
  } dcs_cmd_e;

  typedef struct packed {
    logic [NBANK-1:0][CW-1:0] rtp;
    logic [NBANK-1:0][CW-1:0] dal;
    logic [CW-1:0]            wtr;
    logic [CW-1:0]            mrd;
    logic [CW-1:0]            mods;
    logic [CW-1:0]            ccd;
    logic [CW-1:0]            mpr;
    logic [CW-1:0]            rrd;
    logic [CW-1:0]            dll;
    logic [3:0][CW-1:0]       faw;
    logic [1:0]               faw_ptr;
    logic [PW-1:0]            rd_pipe;
    logic [PW-1:0]            wr_pipe;
    dcs_cmd_e                 cmd;
    logic [2:0]               bank;
    logic                     ap;
    logic                     rd_win;
    logic                     dqs_oe_n;
    logic                     wdata_en;
  } dcs_st_s;
endpackage

/* testbench/dcs_dram_model.sv */
// device model: drives read strobe, frames expected write strobe
// assumes ce_i low also stops the device clock
module dcs_dram_model #(
  parameter int CL  = 5,
  parameter int CWL = 5
) (
  input  wire logic         ref_clk_i,
  input  wire logic         resetn_i,
  input  wire logic         ce_i,
  input  dcs_pkg::dcs_cmd_e cmd_i,
  output logic              rd_dqs_o,
  output logic              wr_oe_n_o,
  output logic              wr_den_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] rd_q;
  logic [15:0] wr_q;
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rd_q <= '0;
      wr_q <= '0;
    end else if (ce_i) begin
      rd_q <= {rd_q[14:0], cmd_i == dcs_pkg::DCS_RD};
      wr_q <= {wr_q[14:0], cmd_i == dcs_pkg::DCS_WR};
    end
  end
  // whole cycles: read and write preambles and the write postamble rounded up to one clock; no read postamble
  always_comb begin
    rd_dqs_o  = |rd_q[CL+2:CL-2];
    wr_oe_n_o = ~|wr_q[CWL+3:CWL-2];
    wr_den_o  = |wr_q[CWL+2:CWL-1];
  end
endmodule

/* testbench/ddr3_command_spacing_checker_bench.sv */
// self-checking bench for the command spacing controller
// assumes design defaults CL=5, CWL=5, 1KB page, 15 ns precharge
module ddr3_command_spacing_checker_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic              ref_clk_i, resetn_i, ce_i, req_valid_i, req_ap_i;
  logic              req_dll_reset_i, req_mpr_exit_i, req_ready_o;
  logic              ddr_ap_o, rd_win_o, wr_dqs_oe_n_o, wr_data_en_o;
  logic              rd_dqs, wr_oe_n_exp, wr_den_exp;
  logic [2:0]        req_bank_i, ddr_bank_o;
  dcs_pkg::dcs_cmd_e req_cmd_i, ddr_cmd_o;
  int                n_errors, comparisons, cyc, t1, ts;

  dcs_ctrl i_dcs_ctrl (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
    .ce_i(ce_i), .req_valid_i(req_valid_i), .req_cmd_i(req_cmd_i),
    .req_bank_i(req_bank_i), .req_ap_i(req_ap_i),
    .req_dll_reset_i(req_dll_reset_i), .req_mpr_exit_i(req_mpr_exit_i),
    .req_ready_o(req_ready_o), .ddr_cmd_o(ddr_cmd_o),
    .ddr_bank_o(ddr_bank_o), .ddr_ap_o(ddr_ap_o), .rd_win_o(rd_win_o),
    .wr_dqs_oe_n_o(wr_dqs_oe_n_o), .wr_data_en_o(wr_data_en_o));
  dcs_dram_model i_dcs_dram_model (.ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i), .ce_i(ce_i), .cmd_i(ddr_cmd_o),
    .rd_dqs_o(rd_dqs), .wr_oe_n_o(wr_oe_n_exp), .wr_den_o(wr_den_exp));

  always #4 ref_clk_i = ~ref_clk_i;
  // cycles counted only while the clock is enabled
  always @(posedge ref_clk_i) if (ce_i) cyc <= cyc + 1;

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // x = {auto precharge, dll reset, mpr exit}
  task automatic go(input dcs_pkg::dcs_cmd_e c, input logic [2:0] b,
                    input logic [2:0] x);
    int n;
    @(posedge ref_clk_i);
    req_valid_i     <= 1'b1;
    req_cmd_i       <= c;
    req_bank_i      <= b;
    {req_ap_i, req_dll_reset_i, req_mpr_exit_i} <= x;
    n = 0;
    do begin
      @(negedge ref_clk_i);
      n++;
    end while (req_ready_o !== 1'b1 && n < 2000);
    t1 = cyc + 1;
    @(posedge ref_clk_i);
    req_valid_i <= 1'b0;
    req_cmd_i   <= dcs_pkg::DCS_NOP;
    @(negedge ref_clk_i);
    check("ddr_cmd_o", ddr_cmd_o, c);
    check("ddr_bank_o", ddr_bank_o, b);
    check("ddr_ap_o", ddr_ap_o, x[2]);
  endtask

  task automatic gap(input string nm, input dcs_pkg::dcs_cmd_e c,
                     input logic [2:0] b, input logic [2:0] x,
                     input int exp);
    int t0;
    t0 = t1;
    go(c, b, x);
    check(nm, t1 - t0, exp);
  endtask

  task automatic idle;
    repeat (20) @(posedge ref_clk_i);
  endtask

  task automatic t_dll;
    go(dcs_pkg::DCS_MRS, 3'h0, 3'h2);
    gap("dll lock", dcs_pkg::DCS_RD, 3'h0, 3'h0, dcs_pkg::DLLK_NCK);
    $display("test dll done");
  endtask

  task automatic t_mrs;
    idle;
    go(dcs_pkg::DCS_MRS, 3'h0, 3'h1);
    gap("mrs mrs", dcs_pkg::DCS_MRS, 3'h1, 3'h0, dcs_pkg::MRD_NCK);
    gap("mrs act", dcs_pkg::DCS_ACT, 3'h1, 3'h0, dcs_pkg::MOD_CYC);
    $display("test mode set done");
  endtask

  task automatic t_col;
    idle;
    go(dcs_pkg::DCS_RD, 3'h0, 3'h0);
    gap("rd pre other", dcs_pkg::DCS_PRE, 3'h1, 3'h0, 2);
    idle;
    go(dcs_pkg::DCS_RD, 3'h0, 3'h0);
    gap("rd pre", dcs_pkg::DCS_PRE, 3'h0, 3'h0, dcs_pkg::RTP_CYC);
    idle;
    go(dcs_pkg::DCS_RD, 3'h0, 3'h0);
    gap("rd wr", dcs_pkg::DCS_WR, 3'h0, 3'h0, dcs_pkg::CCD_NCK);
    gap("wr rd", dcs_pkg::DCS_RD, 3'h0, 3'h0,
        5 + dcs_pkg::BL_HALF + dcs_pkg::WTR_CYC);
    idle;
    go(dcs_pkg::DCS_WR, 3'h3, 3'h4);
    gap("dal", dcs_pkg::DCS_ACT, 3'h3, 3'h0,
        dcs_pkg::WR_CYC + (15000 + 7999) / 8000);
    $display("test column done");
  endtask

  task automatic t_act;
    idle;
    go(dcs_pkg::DCS_ACT, 3'h0, 3'h0);
    ts = t1;
    for (int b = 1; b < 5; b++)
      gap("act act", dcs_pkg::DCS_ACT, 3'(b), 3'h0, dcs_pkg::RRD_CYC);
    check("four act", t1 - ts, (4 * dcs_pkg::RRD_CYC > dcs_pkg::FAW1_CYC) ?
          4 * dcs_pkg::RRD_CYC : dcs_pkg::FAW1_CYC);
    $display("test activate done");
  endtask

  // frozen cycles must not count toward spacing
  task automatic t_ce;
    idle;
    go(dcs_pkg::DCS_RD, 3'h2, 3'h0);
    @(posedge ref_clk_i);
    ce_i <= 1'b0;
    repeat (10) @(posedge ref_clk_i);
    ce_i <= 1'b1;
    gap("frozen rd pre", dcs_pkg::DCS_PRE, 3'h2, 3'h0,
        dcs_pkg::RTP_CYC);
    $display("test clock enable done");
  endtask

  always @(negedge ref_clk_i) begin
    if (resetn_i === 1'b1 && ce_i === 1'b1) begin
      check("rd_win_o", rd_win_o, rd_dqs);
      check("wr_dqs_oe_n_o", wr_dqs_oe_n_o, wr_oe_n_exp);
      check("wr_data_en_o", wr_data_en_o, wr_den_exp);
    end
  end

  initial begin
    #160000;
    n_errors++;
    report_and_stop;
  end

  initial begin
    ref_clk_i = 1'b0;
    resetn_i = 1'b0;
    ce_i = 1'b1;
    req_valid_i = 1'b0;
    req_cmd_i = dcs_pkg::DCS_NOP;
    req_bank_i = 3'h0;
    {req_ap_i, req_dll_reset_i, req_mpr_exit_i} = 3'h0;
    {n_errors, comparisons, cyc} = '0;
    repeat (20) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    @(negedge ref_clk_i);
    check("reset ready", req_ready_o, 1'b1);
    check("reset cmd", ddr_cmd_o, dcs_pkg::DCS_NOP);
    check("reset oe_n", wr_dqs_oe_n_o, 1'b1);
    $display("test reset done");
    t_dll;
    t_mrs;
    t_col;
    t_act;
    t_ce;
    idle;
    report_and_stop;
  end
endmodule
